// ---- core/gpcfg_pkg.sv ----
// package for the eight-pin general-purpose port configuration block
// assumes a single clock domain and a plain register port
package gpcfg_pkg;
  localparam int          GPCFG_NPINS      = 8;
  localparam logic [11:0] GPCFG_CFG_OFFSET = 12'h028;
  localparam int          GPCFG_SEL_LSB    = 24;
  localparam int          GPCFG_DRV_LSB    = 16;
  localparam int          GPCFG_DIR_LSB    = 8;
  localparam int          GPCFG_DAT_LSB    = 0;
  localparam logic [7:0]  GPCFG_SEL_RESET  = 8'hFF;
  localparam logic [7:0]  GPCFG_DRV_RESET  = 8'h00;
  localparam logic [7:0]  GPCFG_DIR_RESET  = 8'h00;

  typedef struct packed {
    logic [7:0] pin_default_function_select;
    logic [7:0] pin_drive_type;
    logic [7:0] pin_direction;
    logic [7:0] pin_data_value;
  } gpcfg_reg_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpcfg_pad_s;

  typedef enum logic [1:0] {
    GPCFG_INIT_CAPTURE,
    GPCFG_INIT_SETTLE,
    GPCFG_INIT_RUN
  } gpcfg_init_e;
endpackage

// ---- core/gpcfg_pad.sv ----
// one pin driver: picks the default function or general-purpose drive
// assumes the owner resolves the wire from out and oe
`timescale 1ns/1ps
module gpcfg_pad
  import gpcfg_pkg::*;
(
  input  wire logic gp_sel,
  input  wire logic drv_pp,
  input  wire logic dir_out,
  input  wire logic data,
  input  wire logic mirror_en,
  input  wire logic mirror_val,
  input  wire logic ext_mii,
  output logic      pad_out,
  output logic      pad_oe
);
  always_comb begin
    pad_out = 1'b0;
    pad_oe  = 1'b0;
    if (ext_mii) begin
      // pin belongs to the external mii, not driven here
      pad_out = 1'b0;
      pad_oe  = 1'b0;
    end else if (gp_sel) begin
      pad_out = mirror_val;
      pad_oe  = mirror_en;
    end else if (dir_out) begin
      if (drv_pp) begin
        pad_out = data;
        pad_oe  = 1'b1;
      end else begin
        // open drain only pulls low
        pad_out = 1'b0;
        pad_oe  = ~data;
      end
    end
  end
endmodule

// ---- core/gpcfg_top.sv ----
// configuration register and pin control for eight general-purpose pins
// assumes pins are outside the clock domain and the board resolves pin wires
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - a set default-function bit routes its pin to its default function, clear means general use.
// - after reset all default-function bits are one so no pin is general-purpose.
// - a pin not in general use may be driven with a mirrored mii signal when mirroring is on.
// - a set drive-type bit gives push/pull, clear gives open-drain, reset zero.
// - a set direction bit makes an output, clear an input, reset all inputs.
// - on an output pin the written data bit appears on the pin.
// - reading the data field returns the sampled pin levels.
// - the data field after reset takes the levels on the pins at that time.
// - pins are unusable for general use while the strap selects the external mii.
// - a pin is a wake or interrupt source only while it is an input.
// - the register is 32 bits at offset 028h and bit n of each field is pin n.
module gpcfg_top
  import gpcfg_pkg::*;
#(
  parameter int NPINS = GPCFG_NPINS
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [11:0]      ADDR,
  input  wire logic [31:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [31:0]      RDATA,
  input  wire logic [NPINS-1:0] PIN_IN,
  output logic      [NPINS-1:0] PIN_OUT,
  output logic      [NPINS-1:0] PIN_OE,
  input  wire logic [NPINS-1:0] MII_MIRROR_VAL,
  input  wire logic             INTERNAL_MII_MIRROR_ENABLE,
  input  wire logic             PHY_INTERFACE_SELECT_STRAP,
  output logic      [NPINS-1:0] PIN_EVENT_SOURCE,
  output logic      [NPINS-1:0] PIN_EVENT_LEVEL
);
  gpcfg_reg_s        cfg_q;
  logic [NPINS-1:0]  pin_meta_q;
  logic [NPINS-1:0]  pin_sync_q;
  logic              strap_meta_q;
  logic              strap_sync_q;
  logic              ext_mii_q;
  gpcfg_init_e       init_q;
  logic              wr_hit;
  logic              rd_hit;
  gpcfg_pad_s        pad;

  assign wr_hit = WR && (ADDR == GPCFG_CFG_OFFSET);
  assign rd_hit = RD && (ADDR == GPCFG_CFG_OFFSET);

  // pins and strap are asynchronous: two flops before anyone looks
  always_ff @(posedge CLK) begin
    pin_meta_q   <= PIN_IN;
    pin_sync_q   <= pin_meta_q;
    strap_meta_q <= PHY_INTERFACE_SELECT_STRAP;
    strap_sync_q <= strap_meta_q;
  end

  // the strap is latched once the synchroniser has settled after reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      init_q <= GPCFG_INIT_CAPTURE;
    end else begin
      case (init_q)
        GPCFG_INIT_CAPTURE: init_q <= GPCFG_INIT_SETTLE;
        GPCFG_INIT_SETTLE:  init_q <= GPCFG_INIT_RUN;
        GPCFG_INIT_RUN:     init_q <= GPCFG_INIT_RUN;
        default:            init_q <= GPCFG_INIT_CAPTURE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_mii_q <= 1'b0;
    end else if (init_q == GPCFG_INIT_SETTLE) begin
      ext_mii_q <= strap_sync_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_q.pin_default_function_select <= GPCFG_SEL_RESET;
      cfg_q.pin_drive_type              <= GPCFG_DRV_RESET;
      cfg_q.pin_direction               <= GPCFG_DIR_RESET;
    end else if (wr_hit) begin
      cfg_q.pin_default_function_select <= WDATA[GPCFG_SEL_LSB +: 8];
      cfg_q.pin_drive_type              <= WDATA[GPCFG_DRV_LSB +: 8];
      cfg_q.pin_direction               <= WDATA[GPCFG_DIR_LSB +: 8];
    end
  end

  // data latch starts as the pin levels so releasing an output keeps its level
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_q.pin_data_value <= 8'h00;
    end else if (wr_hit) begin
      cfg_q.pin_data_value <= WDATA[GPCFG_DAT_LSB +: 8];
    end else if (init_q == GPCFG_INIT_SETTLE) begin
      cfg_q.pin_data_value <= pin_sync_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= 32'h0000_0000;
    end else if (rd_hit) begin
      RDATA <= {cfg_q.pin_default_function_select, cfg_q.pin_drive_type,
                cfg_q.pin_direction, pin_sync_q};
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pad
      gpcfg_pad u_pad (
        .gp_sel     (cfg_q.pin_default_function_select[g]),
        .drv_pp     (cfg_q.pin_drive_type[g]),
        .dir_out    (cfg_q.pin_direction[g]),
        .data       (cfg_q.pin_data_value[g]),
        .mirror_en  (INTERNAL_MII_MIRROR_ENABLE),
        .mirror_val (MII_MIRROR_VAL[g]),
        .ext_mii    (ext_mii_q),
        .pad_out    (pad.out[g]),
        .pad_oe     (pad.oe[g])
      );
    end
  endgenerate

  assign PIN_OUT = pad.out;
  assign PIN_OE  = pad.oe;

  // wake logic outside must still apply its own enable and polarity
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIN_EVENT_SOURCE <= '0;
      PIN_EVENT_LEVEL  <= '0;
    end else begin
      PIN_EVENT_SOURCE <= ~cfg_q.pin_direction & ~cfg_q.pin_default_function_select
                          & {NPINS{~ext_mii_q}};
      PIN_EVENT_LEVEL  <= pin_sync_q;
    end
  end

  a_read_pins : assert property (@(posedge CLK) disable iff (RESET)
    rd_hit |=> RDATA[7:0] == $past(pin_sync_q))
    else $error("read data does not show pin levels");
  a_reset_sel : assert property (@(posedge CLK)
    $fell(RESET) |-> cfg_q.pin_default_function_select == 8'hFF)
    else $error("select field not all ones after reset");
  a_reset_dir : assert property (@(posedge CLK)
    $fell(RESET) |-> cfg_q.pin_direction == 8'h00 && cfg_q.pin_drive_type == 8'h00)
    else $error("direction or drive type not zero after reset");
  a_write_cfg : assert property (@(posedge CLK) disable iff (RESET)
    wr_hit |=> cfg_q.pin_direction == $past(WDATA[15:8]))
    else $error("direction field not written");
  a_pp_drive : assert property (@(posedge CLK) disable iff (RESET)
    !ext_mii_q && !cfg_q.pin_default_function_select[0] && cfg_q.pin_direction[0]
    && cfg_q.pin_drive_type[0] |-> PIN_OE[0] && PIN_OUT[0] == cfg_q.pin_data_value[0])
    else $error("push pull pin not driving data");
  a_od_drive : assert property (@(posedge CLK) disable iff (RESET)
    !ext_mii_q && !cfg_q.pin_default_function_select[1] && cfg_q.pin_direction[1]
    && !cfg_q.pin_drive_type[1] |-> !PIN_OUT[1] && PIN_OE[1] == !cfg_q.pin_data_value[1])
    else $error("open drain pin wrong");
  a_ext_mii : assert property (@(posedge CLK) disable iff (RESET)
    ext_mii_q |-> PIN_OE == '0)
    else $error("pin driven in external mii mode");
  a_input_oe : assert property (@(posedge CLK) disable iff (RESET)
    !cfg_q.pin_default_function_select[2] && !cfg_q.pin_direction[2] |-> !PIN_OE[2])
    else $error("input pin driven");
  a_event_src : assert property (@(posedge CLK) disable iff (RESET)
    PIN_EVENT_SOURCE[3] |-> $past(!cfg_q.pin_direction[3]))
    else $error("output pin flagged as event source");
  a_data_init : assert property (@(posedge CLK) disable iff (RESET)
    init_q == GPCFG_INIT_SETTLE && !wr_hit |=> cfg_q.pin_data_value == $past(pin_sync_q))
    else $error("data field not loaded from pins");
  a_mirror : assert property (@(posedge CLK) disable iff (RESET)
    !ext_mii_q && cfg_q.pin_default_function_select[4] && INTERNAL_MII_MIRROR_ENABLE
    |-> PIN_OE[4] && PIN_OUT[4] == MII_MIRROR_VAL[4])
    else $error("mirror not driven");

  // field by field against the package layout, so a swapped slice shows up
  a_write_sel : assert property (@(posedge CLK) disable iff (RESET)
    wr_hit
    |=> cfg_q.pin_default_function_select == $past(WDATA[GPCFG_SEL_LSB +: 8]))
    else $error("select field not written");

  a_write_drv : assert property (@(posedge CLK) disable iff (RESET)
    wr_hit
    |=> cfg_q.pin_drive_type == $past(WDATA[GPCFG_DRV_LSB +: 8]))
    else $error("drive type field not written");

  a_write_data : assert property (@(posedge CLK) disable iff (RESET)
    wr_hit
    |=> cfg_q.pin_data_value == $past(WDATA[GPCFG_DAT_LSB +: 8]))
    else $error("data field not written");

  a_cfg_hold : assert property (@(posedge CLK) disable iff (RESET)
    !wr_hit
    |=> $stable({cfg_q.pin_default_function_select, cfg_q.pin_drive_type,
                 cfg_q.pin_direction}))
    else $error("config changed without a write");

  a_unmapped_wr : assert property (@(posedge CLK) disable iff (RESET)
    WR && ADDR != GPCFG_CFG_OFFSET
    |=> $stable({cfg_q.pin_default_function_select, cfg_q.pin_drive_type,
                 cfg_q.pin_direction}))
    else $error("unmapped write changed config");

  a_read_fields : assert property (@(posedge CLK) disable iff (RESET)
    rd_hit
    |=> RDATA[31:8] == $past({cfg_q.pin_default_function_select, cfg_q.pin_drive_type,
                              cfg_q.pin_direction}))
    else $error("read fields out of place");

  a_unmapped_rd : assert property (@(posedge CLK) disable iff (RESET)
    RD && ADDR != GPCFG_CFG_OFFSET
    |=> RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_idle_rdata : assert property (@(posedge CLK) disable iff (RESET)
    !rd_hit
    |=> RDATA == 32'h0000_0000)
    else $error("read data held past its cycle");

  a_reset_rdata : assert property (@(posedge CLK)
    RESET
    |=> RDATA == 32'h0000_0000)
    else $error("read data not cleared by reset");

  a_reset_evt : assert property (@(posedge CLK)
    RESET
    |=> PIN_EVENT_SOURCE == '0)
    else $error("event sources not cleared by reset");

  a_init_walk : assert property (@(posedge CLK)
    $fell(RESET)
    |-> init_q == GPCFG_INIT_CAPTURE
    ##1 init_q == GPCFG_INIT_SETTLE ##1 init_q == GPCFG_INIT_RUN)
    else $error("start-up sequence out of order");

  a_strap_load : assert property (@(posedge CLK) disable iff (RESET)
    init_q == GPCFG_INIT_SETTLE
    |=> ext_mii_q == $past(strap_sync_q))
    else $error("strap not latched after reset");

  a_strap_hold : assert property (@(posedge CLK) disable iff (RESET)
    init_q == GPCFG_INIT_RUN
    |=> $stable(ext_mii_q))
    else $error("strap changed while running");

  a_event_ext : assert property (@(posedge CLK) disable iff (RESET)
    ext_mii_q
    |=> PIN_EVENT_SOURCE == '0)
    else $error("event source in external mii mode");

  a_event_level : assert property (@(posedge CLK) disable iff (RESET)
    1'b1
    |=> PIN_EVENT_LEVEL == $past(pin_sync_q))
    else $error("event level not the synced pin");

  // the same pad checks on every pin, since bit n of each field is pin n
  generate
    for (g = 0; g < NPINS; g++) begin : g_chk
      a_pin_pp : assert property (@(posedge CLK) disable iff (RESET)
        !ext_mii_q && !cfg_q.pin_default_function_select[g] && cfg_q.pin_direction[g]
        && cfg_q.pin_drive_type[g] |-> PIN_OE[g] && PIN_OUT[g] == cfg_q.pin_data_value[g])
        else $error("push pull pin not driving data");

      a_pin_od : assert property (@(posedge CLK) disable iff (RESET)
        !ext_mii_q && !cfg_q.pin_default_function_select[g] && cfg_q.pin_direction[g]
        && !cfg_q.pin_drive_type[g] |-> !PIN_OUT[g] && PIN_OE[g] == !cfg_q.pin_data_value[g])
        else $error("open drain pin wrong");

      a_pin_input : assert property (@(posedge CLK) disable iff (RESET)
        !cfg_q.pin_default_function_select[g] && !cfg_q.pin_direction[g]
        |-> !PIN_OE[g])
        else $error("input pin driven");

      a_pin_mirror : assert property (@(posedge CLK) disable iff (RESET)
        !ext_mii_q && cfg_q.pin_default_function_select[g] && INTERNAL_MII_MIRROR_ENABLE
        |-> PIN_OE[g] && PIN_OUT[g] == MII_MIRROR_VAL[g])
        else $error("mirror not driven");

      a_pin_release : assert property (@(posedge CLK) disable iff (RESET)
        cfg_q.pin_default_function_select[g] && !INTERNAL_MII_MIRROR_ENABLE
        |-> !PIN_OE[g])
        else $error("default function pin driven without mirror");

      a_pin_event : assert property (@(posedge CLK) disable iff (RESET)
        PIN_EVENT_SOURCE[g]
        |-> $past(!cfg_q.pin_direction[g] && !cfg_q.pin_default_function_select[g]))
        else $error("pin flagged as event source while not a general input");
    end
  endgenerate

  c_write : cover property (@(posedge CLK) disable iff (RESET) wr_hit);
  c_read  : cover property (@(posedge CLK) disable iff (RESET) rd_hit ##1 RD);
  c_od    : cover property (@(posedge CLK) disable iff (RESET)
    cfg_q.pin_direction[1] && !cfg_q.pin_drive_type[1] && !cfg_q.pin_default_function_select[1]);
  c_evt   : cover property (@(posedge CLK) disable iff (RESET) PIN_EVENT_SOURCE != '0);
  c_mirror : cover property (@(posedge CLK) disable iff (RESET)
    !ext_mii_q && INTERNAL_MII_MIRROR_ENABLE && cfg_q.pin_default_function_select != '0);
endmodule

// ---- tb/gpcfg_board.sv ----
// board model: resolves each pin wire from the device drive and board sources
// assumes a pull-up on every pin, so a released open-drain pin reads high while ext_en is low, ext_val otherwise
`timescale 1ns/1ps
module gpcfg_board
  import gpcfg_pkg::*;
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic       ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_lvl
);
  // board sources yield to the device so a driven pin never fights
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en ? ext_val[i] : 1'b1);
    end
  end
endmodule

// ---- tb/gpcfg_top_tb.sv ----
// self-checking bench for the pin configuration block
// assumes the board model closes the pin loop and the register port never stalls
`timescale 1ns/1ps
module gpcfg_top_tb;
  import gpcfg_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [7:0]  pin_in, pin_out, pin_oe, mii_val = 8'h00, ev_src, ev_lvl;
  logic [7:0]  ext_val = 8'hA5;
  logic        mir_en = 1'b0, strap = 1'b0, ext_en = 1'b1;
  int          fails = 0, check_count = 0;
  always #4 clk = ~clk;
  gpcfg_top i_dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .MII_MIRROR_VAL(mii_val), .INTERNAL_MII_MIRROR_ENABLE(mir_en),
    .PHY_INTERFACE_SELECT_STRAP(strap), .PIN_EVENT_SOURCE(ev_src), .PIN_EVENT_LEVEL(ev_lvl));
  gpcfg_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(pin_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // pins settle through the two-flop synchroniser before a read can see them
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic t_reset();
    do_reset();
    chk({24'h0, pin_oe}, 32'h0);
    bus_rd(GPCFG_CFG_OFFSET, v);
    chk(v, 32'hFF0000A5);
  endtask
  task automatic t_pushpull();
    ext_val <= 8'h3C;
    bus_wr(GPCFG_CFG_OFFSET, 32'h00FF0F05);
    chk({24'h0, pin_oe}, 32'h0F);
    chk({24'h0, pin_out & 8'h0F}, 32'h05);
    settle();
    bus_rd(GPCFG_CFG_OFFSET, v);
    chk(v, 32'h00FF0F35);
    chk({24'h0, ev_src}, 32'hF0);
    chk({24'h0, ev_lvl}, 32'h35);
  endtask
  task automatic t_opendrain();
    ext_en <= 1'b0;
    bus_wr(GPCFG_CFG_OFFSET, 32'h0000FF0F);
    chk({16'h0, pin_oe, pin_out}, 32'hF000);
    settle();
    bus_rd(GPCFG_CFG_OFFSET, v);
    chk(v, 32'h0000FF0F);
    chk({24'h0, ev_src}, 32'h00);
  endtask
  task automatic t_mirror();
    @(posedge clk);
    mir_en <= 1'b1;
    mii_val <= 8'h5A;
    bus_wr(GPCFG_CFG_OFFSET, 32'hF0FFFF0C);
    chk({16'h0, pin_oe, pin_out}, 32'hFF5C);
    @(posedge clk);
    mir_en <= 1'b0;
    @(posedge clk);
    #1 chk({24'h0, pin_oe}, 32'h0F);
  endtask
  task automatic t_unmapped();
    bus_wr(12'h02C, 32'h00000000);
    bus_rd(12'h02C, v);
    chk(v, 32'h0);
    bus_rd(GPCFG_CFG_OFFSET, v);
    chk(v & 32'hFFFFFF00, 32'hF0FFFF00);
  endtask
  task automatic t_strap();
    @(posedge clk);
    strap <= 1'b1;
    do_reset();
    bus_wr(GPCFG_CFG_OFFSET, 32'h00FFFF55);
    chk({24'h0, pin_oe}, 32'h0);
    settle();
    chk({24'h0, ev_src}, 32'h0);
    bus_rd(GPCFG_CFG_OFFSET, v);
    chk(v & 32'hFFFFFF00, 32'h00FFFF00);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_pushpull();
    t_opendrain();
    t_mirror();
    t_unmapped();
    t_strap();
    complete_run();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    complete_run();
  end
endmodule
